// ---- core/vcc_regs.sv ----
// control register bank of the voice codec, with its serial control port
// assumes: mclk runs free; the port clock runs only while the port is
// selected; the frame strobe and bit clock arrive unrelated to mclk
//
// How it works
// - basic mode bit 5 commands power-down
// - sleep is register bit OR pin low
// - sleep pin low restores every register default
// - compression bits pick 4,8,3,2 bit codes
// - bits 5,4 reset encoder and decoder
// - bits 3,2 mute transmit and receive
// - bit 0 adds 12 dB receive pad
// - gain bits 7,3 switch channels off
// - gain codes map -6 to +8 dB
// - side-tone code 0 off, else -21..-9 dB
// - side bit 1 picks high-pass corner
// - side bit 0 bypasses high-pass filter
// - latch timing derives from frame strobe
// - burst or continuous bit clock accepted
// - 3-bit address selects four registers
// - serial port reads and writes; quiet asleep
// - side bit 1 also marks 11.025 kHz
`timescale 1ns/1ns
module vcc_regs
   import vcc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sleep_pin_n,
   input wire logic frame_strobe,
   input wire logic bit_clock,
   input wire logic ctrl_port_clock,
   input wire logic ctrl_port_select,
   input wire logic ctrl_din,
   output logic ctrl_dout_o,
   output logic ctrl_dout_oe,
   output logic system_sleep,
   output logic frame_tick,
   output logic pcm_latch,
   output logic adpcm_latch,
   output logic slip_seen,
   output vcc_cfg_s cfg
);

   // ****************************************************************
   // decode helpers
   // ****************************************************************

   // code width per sample from the compression pair
   function automatic logic [3:0] vcc_code_bits(input logic [1:0] sel);
      logic [3:0] w;
      w = 4'h4;
      unique case (sel)
         2'b00: w = 4'h4;
         2'b01: w = 4'h8;
         2'b10: w = 4'h3;
         2'b11: w = 4'h2;
      endcase
      return w;
   endfunction : vcc_code_bits

   // 2 dB steps from -6 dB
   function automatic logic signed [4:0] vcc_gain_db(input logic [2:0] c);
      return $signed({1'b0, c, 1'b0}) - 5'sd6;
   endfunction : vcc_gain_db

   // ****************************************************************
   // link domain: serial control port
   // ****************************************************************
   logic link_clr;
   logic [4:0] bit_cnt;
   logic [14:0] shift;
   logic [7:0] rd_sh;
   logic [15:0] wr_word;
   logic wr_tog;
   logic sleep_l1;
   logic sleep_l2;
   logic [7:0] img [0:3];
   logic [7:0] img_byte;
   logic [7:0] hdr;

   // a dropped select ends the frame without needing a further clock edge
   assign link_clr = reset | ~ctrl_port_select;
   assign hdr = {shift[6:0], ctrl_din};

   // image is frozen while the port is selected, so this mux is steady
   always_comb
   begin
      img_byte = 8'h00;
      if (hdr[6:2] == 5'h00)
      begin
         img_byte = img[hdr[1:0]];
      end
   end

   // sleep level seen from the port clock, for the output enable
   always_ff @(posedge ctrl_port_clock or posedge reset)
   begin
      if (reset)
      begin
         sleep_l1 <= 1'b0;
         sleep_l2 <= 1'b0;
      end
      else
      begin
         sleep_l1 <= system_sleep;
         sleep_l2 <= sleep_l1;
      end
   end

   // bit counter and input shifter, cleared whenever select is low
   always_ff @(posedge ctrl_port_clock or posedge link_clr)
   begin
      if (link_clr)
      begin
         bit_cnt <= 5'h00;
         shift <= 15'h0000;
      end
      else
      begin
         if (bit_cnt != WORD_BITS)
         begin
            bit_cnt <= bit_cnt + 5'h01;
         end
         shift <= {shift[13:0], ctrl_din};
      end
   end

   // read data out, most significant bit first, after the header
   always_ff @(posedge ctrl_port_clock or posedge link_clr)
   begin
      if (link_clr)
      begin
         rd_sh <= 8'h00;
         ctrl_dout_o <= 1'b0;
         ctrl_dout_oe <= 1'b0;
      end
      else if (bit_cnt == HDR_LAST && hdr[HDR_RW_POS])
      begin
         rd_sh <= img_byte;
         ctrl_dout_o <= img_byte[7];
         ctrl_dout_oe <= ~sleep_l2;
      end
      else if (bit_cnt > HDR_LAST && bit_cnt < WORD_LAST)
      begin
         rd_sh <= {rd_sh[6:0], 1'b0};
         ctrl_dout_o <= rd_sh[6];
      end
      else
      begin
         ctrl_dout_o <= 1'b0;
         ctrl_dout_oe <= 1'b0;
      end
   end

   // finished write word and its toggle survive the end of the frame
   always_ff @(posedge ctrl_port_clock or posedge reset)
   begin
      if (reset)
      begin
         wr_word <= 16'h0000;
         wr_tog <= 1'b0;
      end
      else if (ctrl_port_select && bit_cnt == WORD_LAST && !shift[14])
      begin
         wr_word <= {shift, ctrl_din};
         wr_tog <= ~wr_tog;
      end
   end

   // ****************************************************************
   // mclk domain: synchronisers
   // ****************************************************************
   logic pin_s1;
   logic pin_s2;
   logic sel_s1;
   logic sel_s2;
   logic [2:0] wt_s;
   logic [2:0] fr_s;
   logic [2:0] bc_s;
   logic wr_pulse;
   logic frame_rise;
   logic bclk_edge;

   // two stages per level input, three per edge-detected input; only the second and later stages are read
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
         wt_s <= 3'h0;
         fr_s <= 3'h0;
         bc_s <= 3'h0;
      end
      else
      begin
         pin_s1 <= sleep_pin_n;
         pin_s2 <= pin_s1;
         sel_s1 <= ctrl_port_select;
         sel_s2 <= sel_s1;
         wt_s <= {wt_s[1:0], wr_tog};
         fr_s <= {fr_s[1:0], frame_strobe};
         bc_s <= {bc_s[1:0], bit_clock};
      end
   end

   assign wr_pulse = wt_s[2] ^ wt_s[1];
   assign frame_rise = fr_s[1] & ~fr_s[2];
   assign bclk_edge = bc_s[1] ^ bc_s[2];

   // ****************************************************************
   // mclk domain: registers
   // ****************************************************************
   logic [7:0] basic_mode;
   logic [7:0] adpcm_mode;
   logic [7:0] channel_gain;
   logic [7:0] sidetone_filter;

   // pin low holds all fields at default; test bits are stored as written
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         basic_mode <= RST_BASIC;
         adpcm_mode <= RST_ADPCM;
         channel_gain <= RST_GAIN;
         sidetone_filter <= RST_SIDE;
      end
      else if (!pin_s2)
      begin
         basic_mode <= RST_BASIC;
         adpcm_mode <= RST_ADPCM;
         channel_gain <= RST_GAIN;
         sidetone_filter <= RST_SIDE;
      end
      else if (wr_pulse && wr_word[14:11] == 4'h0)
      begin
         unique case (wr_word[10:8])
            ADR_BASIC: basic_mode <= wr_word[7:0];
            ADR_ADPCM: adpcm_mode <= wr_word[7:0];
            ADR_GAIN: channel_gain <= wr_word[7:0];
            ADR_SIDE: sidetone_filter <= wr_word[7:0];
            default: ;
         endcase
      end
   end

   // image refreshed only while the port is idle: select is the handshake
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         img[0] <= RST_BASIC;
         img[1] <= RST_ADPCM;
         img[2] <= RST_GAIN;
         img[3] <= RST_SIDE;
      end
      else if (!sel_s2)
      begin
         img[0] <= basic_mode;
         img[1] <= adpcm_mode;
         img[2] <= channel_gain;
         img[3] <= sidetone_filter;
      end
   end

   // sleep follows at once; it is not a per-sample setting
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         system_sleep <= 1'b1;
      end
      else
      begin
         system_sleep <= basic_mode[SLEEP_POS] | ~pin_s2;
      end
   end

   // ****************************************************************
   // mclk domain: frame timing
   // ****************************************************************
   logic [11:0] fcnt;
   logic near_a;
   logic near_b;

   // only the strobe drives timing, so a stopped bit clock does no harm
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         fcnt <= 12'hFFF;
      end
      else if (frame_rise)
      begin
         fcnt <= 12'h000;
      end
      else if (fcnt != 12'hFFF)
      begin
         fcnt <= fcnt + 12'h001;
      end
   end

   assign near_a = fcnt >= LATCH_A_CYC - GUARD_CYC
      && fcnt <= LATCH_A_CYC + GUARD_CYC;
   assign near_b = fcnt >= LATCH_B_CYC - GUARD_CYC
      && fcnt <= LATCH_B_CYC + GUARD_CYC;

   // latch strobes and a slip warning for edges too close to them
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         frame_tick <= 1'b0;
         pcm_latch <= 1'b0;
         adpcm_latch <= 1'b0;
         slip_seen <= 1'b0;
      end
      else
      begin
         frame_tick <= frame_rise;
         pcm_latch <= fcnt == LATCH_A_CYC;
         adpcm_latch <= fcnt == LATCH_B_CYC;
         slip_seen <= (bclk_edge | frame_rise) & (near_a | near_b);
      end
   end

   // ****************************************************************
   // mclk domain: settings carried to the datapath
   // ****************************************************************

   // copied only on a frame edge, so one sample never sees mixed settings
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cfg <= '0;
         cfg.code_bits <= 4'h4;
         cfg.pad_db <= PAD_LOSS_DB;
         cfg.tx_gain_db <= 5'sd0;
         cfg.rx_gain_db <= 5'sd0;
      end
      else if (frame_rise)
      begin
         cfg.code_bits <= vcc_code_bits(
            {adpcm_mode[CMP_HI_POS], adpcm_mode[CMP_LO_POS]});
         cfg.enc_reset <= adpcm_mode[ENC_RST_POS];
         cfg.dec_reset <= adpcm_mode[DEC_RST_POS];
         cfg.tx_mute <= adpcm_mode[TX_MUTE_POS];
         cfg.rx_mute <= adpcm_mode[RX_MUTE_POS];
         cfg.rx_pad <= adpcm_mode[PAD_POS];
         cfg.pad_db <= PAD_LOSS_DB;
         cfg.tx_off <= channel_gain[TX_OFF_POS];
         cfg.rx_off <= channel_gain[RX_OFF_POS];
         cfg.tx_gain_db <= vcc_gain_db(channel_gain[6:4]);
         cfg.rx_gain_db <= vcc_gain_db(channel_gain[2:0]);
         cfg.st_on <= sidetone_filter[7:5] != 3'h0;
         cfg.st_gain_db <= (sidetone_filter[7:5] == 3'h0) ? 6'sd0
            : $signed({2'b00, sidetone_filter[7:5], 1'b0})
            - 6'sd23;
         cfg.hp_corner <= sidetone_filter[HP_CORNER_POS];
         cfg.hp_bypass <= sidetone_filter[HP_BYPASS_POS];
         cfg.rate_11k <= sidetone_filter[HP_CORNER_POS];
      end
   end

endmodule : vcc_regs

// ---- core/vcc_pkg.sv ----
// constants, field positions and the settings carrier of the voice codec
// control register bank; shared by the bank and by whatever consumes it
package vcc_pkg;

   // ****************************************************************
   // register addresses on the serial control port
   // ****************************************************************
   localparam logic [2:0] ADR_BASIC = 3'h0;
   localparam logic [2:0] ADR_ADPCM = 3'h1;
   localparam logic [2:0] ADR_GAIN = 3'h2;
   localparam logic [2:0] ADR_SIDE = 3'h3;

   // values taken while the sleep pin is low
   localparam logic [7:0] RST_BASIC = 8'h00;
   localparam logic [7:0] RST_ADPCM = 8'h00;
   localparam logic [7:0] RST_GAIN = 8'h33;
   localparam logic [7:0] RST_SIDE = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int SLEEP_POS = 5;
   localparam int CMP_HI_POS = 7;
   localparam int CMP_LO_POS = 6;
   localparam int ENC_RST_POS = 5;
   localparam int DEC_RST_POS = 4;
   localparam int TX_MUTE_POS = 3;
   localparam int RX_MUTE_POS = 2;
   localparam int PAD_POS = 0;
   localparam int TX_OFF_POS = 7;
   localparam int RX_OFF_POS = 3;
   localparam int HP_CORNER_POS = 1;
   localparam int HP_BYPASS_POS = 0;
   localparam int HDR_RW_POS = 7;
   localparam logic [4:0] HDR_LAST = 5'h07;
   localparam logic [4:0] WORD_LAST = 5'h0F;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] PAD_LOSS_DB = 5'h0C;

   // ****************************************************************
   // timing against the 8 ns clock
   // ****************************************************************
   localparam int MCLK_NS = 8;
   localparam int LATCH_A_NS = 2000;
   localparam int LATCH_B_NS = 4000;
   localparam int GUARD_NS = 1000;
   localparam logic [11:0] LATCH_A_CYC =
      12'((LATCH_A_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [11:0] LATCH_B_CYC =
      12'((LATCH_B_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [11:0] GUARD_CYC =
      12'((GUARD_NS + MCLK_NS - 1) / MCLK_NS);

   // settings as the datapath sees them
   typedef struct packed {
      logic [3:0] code_bits;
      logic enc_reset;
      logic dec_reset;
      logic tx_mute;
      logic rx_mute;
      logic rx_pad;
      logic [4:0] pad_db;
      logic tx_off;
      logic rx_off;
      logic signed [4:0] tx_gain_db;
      logic signed [4:0] rx_gain_db;
      logic st_on;
      logic signed [5:0] st_gain_db;
      logic hp_corner;
      logic hp_bypass;
      logic rate_11k;
   } vcc_cfg_s;

endpackage : vcc_pkg

// ---- verification/vcc_regs_monitor.sv ----
// checker for the control bank: frame timing, settings and sleep
// assumes all of it can be judged on mclk alone
`timescale 1ns/1ns
module vcc_regs_monitor
   import vcc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sleep_pin_n,
   input wire logic frame_strobe,
   input wire logic bit_clock,
   input wire logic ctrl_port_clock,
   input wire logic ctrl_port_select,
   input wire logic ctrl_din,
   input wire logic ctrl_dout_o,
   input wire logic ctrl_dout_oe,
   input wire logic system_sleep,
   input wire logic frame_tick,
   input wire logic pcm_latch,
   input wire logic adpcm_latch,
   input wire logic slip_seen,
   input wire vcc_cfg_s cfg
);
   // ****************************************
   // frame start, then the two latch points
   // ****************************************
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence s_frame;
      frame_tick;
   endsequence
   sequence s_pcm;
      ##[249:251] pcm_latch;
   endsequence
   sequence s_adpcm;
      ##[499:501] adpcm_latch;
   endsequence
   tick_follow_a: assert property (
      $rose(frame_strobe) |-> ##[2:4] s_frame)
      else $error("frame tick late after strobe");
   pcm_point_a: assert property (s_frame |-> s_pcm)
      else $error("pcm latch off its offset");
   adpcm_point_a: assert property (s_frame |-> s_adpcm)
      else $error("adpcm latch off its offset");
   // settings may only move together with a frame tick
   cfg_frame_a: assert property (!$stable(cfg) |-> frame_tick)
      else $error("settings changed between frames");
   pin_sleep_a: assert property (!sleep_pin_n [*4] |-> system_sleep)
      else $error("pin low but not asleep");
   quiet_dout_a: assert property (
      system_sleep [*3] |-> !$rose(ctrl_dout_oe))
      else $error("read data driven while asleep");
   code_set_a: assert property (
      cfg.code_bits inside {4'h4, 4'h8, 4'h3, 4'h2})
      else $error("illegal code width");
   pad_fixed_a: assert property (cfg.pad_db == PAD_LOSS_DB)
      else $error("pad loss not fixed");
   st_map_a: assert property (
      cfg.st_on ? (cfg.st_gain_db inside {[-21:-9]}
      && cfg.st_gain_db[0]) : cfg.st_gain_db == 6'sh00)
      else $error("side-tone level off the ladder");
   rate_mark_a: assert property (cfg.rate_11k == cfg.hp_corner)
      else $error("rate flag differs from corner select");
endmodule : vcc_regs_monitor

bind vcc_regs vcc_regs_monitor i_mon (
   .mclk(mclk), .reset(reset), .sleep_pin_n(sleep_pin_n),
   .frame_strobe(frame_strobe), .bit_clock(bit_clock),
   .ctrl_port_clock(ctrl_port_clock), .ctrl_port_select(ctrl_port_select),
   .ctrl_din(ctrl_din), .ctrl_dout_o(ctrl_dout_o),
   .ctrl_dout_oe(ctrl_dout_oe), .system_sleep(system_sleep),
   .frame_tick(frame_tick), .pcm_latch(pcm_latch),
   .adpcm_latch(adpcm_latch), .slip_seen(slip_seen), .cfg(cfg)
);

// ---- verification/vcc_host_model.sv ----
// microcontroller side of the serial control port
// assumes a 12 ns port clock that runs only inside a frame
`timescale 1ns/1ns
module vcc_host_model (
   output logic ctrl_port_clock,
   output logic ctrl_port_select,
   output logic ctrl_din,
   input wire logic ctrl_dout_o,
   input wire logic ctrl_dout_oe
);
   logic oe_seen;
   initial
   begin
      ctrl_port_clock = 1'b0;
      ctrl_port_select = 1'b0;
      ctrl_din = 1'b1;
      oe_seen = 1'b0;
   end
   // ****************************************
   // one 16-bit frame, msb first
   // ****************************************
   task automatic xfer(input logic [15:0] word, output logic [7:0] rdata);
      rdata = 8'h00;
      oe_seen = 1'b0;
      #5 ctrl_port_select = 1'b1;
      for (int i = 15; i >= 0; i--)
      begin
         ctrl_din = word[i];
         #6 ctrl_port_clock = 1'b1;
         #6 ctrl_port_clock = 1'b0;
         // read bits are taken on falling edges, b7 after edge 8
         if (i >= 1 && i <= 8)
         begin
            rdata[i - 1] = ctrl_dout_o & ctrl_dout_oe;
            oe_seen = oe_seen | ctrl_dout_oe;
         end
      end
      #6 ctrl_port_select = 1'b0;
      ctrl_din = ~ctrl_din; // released line shows no stale value
      #60; // gap lets the read image refresh
   endtask : xfer
endmodule : vcc_host_model

// ---- verification/voice_codec_control_regs_bench.sv ----
// bench of the voice codec control bank, its port and frame timing
// assumes vcc_host_model plays the microcontroller on the port
`timescale 1ns/1ns
module voice_codec_control_regs_bench
   import vcc_pkg::*;
();
   logic mclk, reset, sleep_pin_n, frame_strobe, bit_clock;
   logic ctrl_port_clock, ctrl_port_select, ctrl_din;
   logic ctrl_dout_o, ctrl_dout_oe, system_sleep, frame_tick;
   logic pcm_latch, adpcm_latch, slip_seen;
   vcc_cfg_s cfg;
   int num_errors, num_checks, slips;
   vcc_regs i_dut (.mclk(mclk), .reset(reset), .sleep_pin_n(sleep_pin_n),
      .frame_strobe(frame_strobe), .bit_clock(bit_clock),
      .ctrl_port_clock(ctrl_port_clock), .ctrl_port_select(ctrl_port_select),
      .ctrl_din(ctrl_din), .ctrl_dout_o(ctrl_dout_o),
      .ctrl_dout_oe(ctrl_dout_oe), .system_sleep(system_sleep),
      .frame_tick(frame_tick), .pcm_latch(pcm_latch),
      .adpcm_latch(adpcm_latch), .slip_seen(slip_seen), .cfg(cfg));
   vcc_host_model i_host (.ctrl_port_clock(ctrl_port_clock),
      .ctrl_port_select(ctrl_port_select), .ctrl_din(ctrl_din),
      .ctrl_dout_o(ctrl_dout_o), .ctrl_dout_oe(ctrl_dout_oe));
   always #4 mclk = ~mclk;
   always @(posedge mclk) if (slip_seen === 1'b1) slips++;
   // ****************************************
   // helpers
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] r;
      i_host.xfer({5'h00, a, d}, r);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      i_host.xfer({5'h10, a, 8'h00}, d);
   endtask : rd
   // burst bit clock near the strobe, edges kept clear of latches unless slip adds one near the pcm latch
   task automatic frame(input bit slip);
      tick(1);
      frame_strobe = 1'b1;
      repeat (8)
      begin
         bit_clock = ~bit_clock;
         tick(4);
      end
      frame_strobe = 1'b0;
      tick(slip ? 220 : 700);
      if (slip)
      begin
         bit_clock = ~bit_clock;
         tick(480);
      end
   endtask : frame
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      logic [7:0] r;
      logic [7:0] dv [4];
      dv = '{RST_BASIC, RST_ADPCM, RST_GAIN, RST_SIDE};
      for (int a = 0; a < 4; a++)
      begin
         rd(3'(a), r);
         check("reset value", r, dv[a]);
      end
      check("reset code", {4'h0, cfg.code_bits}, 8'h04);
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs;
      logic [7:0] r;
      logic [7:0] pat [4];
      pat = '{8'h00, 8'hF5, 8'hA5, 8'hE3};
      for (int a = 0; a < 4; a++)
         wr(3'(a), pat[a]);
      check("early cfg", {7'h0, cfg.tx_off}, 8'h00);
      wr(3'h4, 8'hAA);
      rd(3'h4, r);
      check("unmapped", r, 8'h00);
      for (int a = 0; a < 4; a++)
      begin
         rd(3'(a), r);
         check("readback", r, pat[a]);
      end
      $display("test regs done");
   endtask : t_regs
   task automatic t_cfg;
      logic [7:0] cb [4];
      logic [2:0] c;
      cb = '{8'h04, 8'h08, 8'h03, 8'h02};
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         wr(ADR_ADPCM, {c[1:0], c[2], c[2], c[0], c[1], 1'b0, c[0]});
         wr(ADR_GAIN, {c[0], c, c[1], ~c});
         wr(ADR_SIDE, {c, 3'h0, c[1], c[0]});
         frame(1'b0);
         check("code", {4'h0, cfg.code_bits}, cb[c[1:0]]);
         check("resets", {6'h0, cfg.enc_reset, cfg.dec_reset},
            {6'h0, c[2], c[2]});
         check("mutes", {6'h0, cfg.tx_mute, cfg.rx_mute},
            {6'h0, c[0], c[1]});
         check("pad", {7'h0, cfg.rx_pad}, {7'h0, c[0]});
         check("off", {6'h0, cfg.tx_off, cfg.rx_off},
            {6'h0, c[0], c[1]});
         check("tx gain", {3'h0, cfg.tx_gain_db},
            {3'h0, 5'(2 * i - 6)});
         check("rx gain", {3'h0, cfg.rx_gain_db},
            {3'h0, 5'(8 - 2 * i)});
         check("side", {1'h0, cfg.st_on, cfg.st_gain_db},
            {1'h0, i != 0, i != 0 ? 6'(2 * i - 23) : 6'h00});
         check("hp", {5'h0, cfg.hp_corner, cfg.hp_bypass, cfg.rate_11k},
            {5'h0, c[1], c[0], c[1]});
      end
      $display("test cfg done");
   endtask : t_cfg
   task automatic t_sleep;
      logic [7:0] r;
      wr(ADR_GAIN, 8'h55);
      wr(ADR_BASIC, 8'h20);
      tick(5);
      check("bit sleep", {7'h0, system_sleep}, 8'h01);
      rd(ADR_GAIN, r);
      check("quiet", {7'h0, i_host.oe_seen}, 8'h00);
      wr(ADR_BASIC, 8'h00);
      tick(5);
      check("wake", {7'h0, system_sleep}, 8'h00);
      sleep_pin_n = 1'b0;
      tick(30);
      check("pin sleep", {7'h0, system_sleep}, 8'h01);
      sleep_pin_n = 1'b1;
      tick(5);
      rd(ADR_GAIN, r);
      check("defaults", r, RST_GAIN);
      $display("test sleep done");
   endtask : t_sleep
   task automatic t_slip;
      int s0;
      s0 = slips;
      frame(1'b0);
      check("no slip", 8'(slips - s0), 8'h00);
      frame(1'b1);
      check("slip", {7'h0, slips != s0}, 8'h01);
      $display("test slip done");
   endtask : t_slip
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // main sequence, then a watchdog well past the expected run
   initial
   begin
      mclk = 1'b0;
      reset = 1'b1;
      sleep_pin_n = 1'b1;
      frame_strobe = 1'b0;
      bit_clock = 1'b0;
      tick(3);
      reset = 1'b0;
      tick(5);
      t_reset;
      t_regs;
      t_cfg;
      t_sleep;
      t_slip;
      stop_test;
   end
   initial
   begin
      #(60000 * 8);
      num_errors++;
      stop_test;
   end
endmodule : voice_codec_control_regs_bench
